// File: src/ppr_pkg.sv
// package: constants and types for the per-phase calibration datapath
// Contract
// - per-phase 12-bit voltage gain scales gained voltage and rms
// - gain is twos complement: times one plus gain/4096
// - corrected rms is raw rms plus offset times 64
// - current times voltage, low-pass, gives active power
// - power range set by power and watt gain
// - 12-bit power offset, one code per energy code
// - offset added at every energy accumulation step; code adds it only for selected phases, a deselected phase steps zero
// - reverse flags at bits 12 to 14
// - flag reads zero unless phase selected
// - 24-bit rms register updated at clock/12
// - total sum includes only selected phases
package ppr_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int NPH         = 3;
  localparam int SMP_W       = 16;
  localparam int GAIN_W      = 12;
  localparam int GAIN_FRAC   = 12;
  localparam int GS_W        = 14;
  localparam int VG_W        = 17;
  localparam int SQ_W        = 34;
  localparam int PW_W        = 33;
  localparam int GM_W        = PW_W + GS_W;
  localparam int LPF_SHIFT   = 4;
  localparam int RMS_W       = 24;
  localparam int REM_W       = RMS_W + 2;
  localparam int CORR_W      = RMS_W + 3;
  localparam int RAD_W       = 48;
  localparam int RAD_PAD     = RAD_W - SQ_W;
  localparam int RMSOS_SHIFT = 6;
  localparam int EBUS_W      = 28;
  localparam int EBUS_SHIFT  = 6;
  localparam int STEP_W      = 29;
  localparam int TOT_W       = 31;
  localparam int CFN_W       = 12;
  localparam int FIFO_DEPTH  = 4;
  // ----------------------------------------------------------------
  // field positions, values and divider counts
  // ----------------------------------------------------------------
  localparam int WM_SEL_LSB  = 3;
  localparam int FD_FLAG_LSB = 12;
  localparam logic signed [GS_W-1:0]   GAIN_ONE   = 14'sh1000;
  localparam logic        [GAIN_W-1:0] GAIN_MIN   = 12'h800;
  localparam logic        [4:0]        SQRT_STEPS = 5'h18;
  localparam logic        [1:0]        ACC_LAST   = 2'h3;
  localparam logic        [3:0]        RMS_LAST   = 4'hb;
  typedef enum logic [1:0] {
    PPR_SQ_IDLE = 2'b00,
    PPR_SQ_RUN  = 2'b01,
    PPR_SQ_DONE = 2'b11
  } ppr_sq_t;
endpackage

// File: src/ppr_fifo.sv
// sample fifo with valid/ready on both sides
`timescale 1ns/1ns
module ppr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);
  // depth must be a power of two so the pointers wrap cleanly
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic         full, empty, push, pop;

  assign full          = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty         = (wr_ptr == rd_ptr);
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];

  always_comb begin
    next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  property p_fifo_full;
    @(posedge core_clk_in) disable iff (rst_in)
      full && !pop |=> !in_ready_out;
  endproperty
  a_fifo_full: assert property (p_fifo_full) else $error("fifo accepted while full");
endmodule

// File: src/ppr_phase_calib.sv
// per-phase voltage gain, rms offset, active power and reverse flags
`timescale 1ns/1ns
module ppr_phase_calib
  import ppr_pkg::*;
(
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         smp_valid_in,
  output logic                              smp_ready_out,
  input  wire logic [NPH-1:0][SMP_W-1:0]    cur_smp_in,
  input  wire logic [NPH-1:0][SMP_W-1:0]    volt_smp_in,
  input  wire logic [NPH-1:0][GAIN_W-1:0]   voltage_gain_in,
  input  wire logic [NPH-1:0][GAIN_W-1:0]   voltage_rms_offset_in,
  input  wire logic [NPH-1:0][GAIN_W-1:0]   power_gain_in,
  input  wire logic [NPH-1:0][GAIN_W-1:0]   watt_gain_in,
  input  wire logic [NPH-1:0][GAIN_W-1:0]   power_offset_in,
  input  wire logic [7:0]                   watt_mode_in,
  input  wire logic [CFN_W-1:0]             cf_numerator_in,
  output logic      [NPH-1:0][VG_W-1:0]     voltage_gained_out,
  output logic      [NPH-1:0][RMS_W-1:0]    voltage_rms_out,
  output logic      [NPH-1:0][EBUS_W-1:0]   active_power_out,
  output logic      [NPH-1:0][STEP_W-1:0]   energy_step_out,
  output logic      [TOT_W-1:0]             total_power_out,
  output logic      [15:0]                  freq_div_reg_out
);
  // ----------------------------------------------------------------
  // shared state
  // ----------------------------------------------------------------
  logic                        fifo_valid, pop, acc_pulse, rms_pulse;
  logic                        s1_valid, next_s1_valid;
  logic [1:0]                  acc_cnt, next_acc_cnt;
  logic [3:0]                  rms_cnt, next_rms_cnt;
  logic [NPH-1:0][SMP_W-1:0]   f_volt, f_cur;
  logic [NPH-1:0]              sel, flags, next_flags;
  logic signed [TOT_W-1:0]     total, next_total;
  logic [CFN_W-1:0]            cfn, next_cfn;
  wire logic [NPH-1:0][STEP_W-1:0] step_c;
  wire logic [NPH-1:0]             neg_c;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // signed gain x * (1 + g/4096), fraction not yet dropped
  function automatic logic signed [GM_W-1:0] gmul(input logic signed [PW_W-1:0] x,
                                                  input logic [GAIN_W-1:0] g);
    logic signed [GS_W-1:0] gs;
    gs   = GAIN_ONE + GS_W'($signed(g));
    gmul = GM_W'(x) * GM_W'(gs);
  endfunction

  // ----------------------------------------------------------------
  // sample buffer
  // ----------------------------------------------------------------
  // one sample set is drained per accumulation step, so a faster
  // source fills the buffer and is held off by smp_ready_out
  ppr_fifo #(
    .W     (2*NPH*SMP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (smp_valid_in),
    .in_data_in    ({volt_smp_in, cur_smp_in}),
    .in_ready_out  (smp_ready_out),
    .out_valid_out (fifo_valid),
    .out_ready_in  (acc_pulse),
    .out_data_out  ({f_volt, f_cur})
  );

  assign acc_pulse = (acc_cnt == ACC_LAST);
  assign rms_pulse = (rms_cnt == RMS_LAST);
  assign pop       = acc_pulse && fifo_valid;

  always_comb begin
    for (int k = 0; k < NPH; k++) begin
      sel[k] = watt_mode_in[WM_SEL_LSB + NPH - 1 - k];
    end
  end

  // ----------------------------------------------------------------
  // per-phase paths
  // ----------------------------------------------------------------
  // replicated phase path
  for (genvar k = 0; k < NPH; k++) begin : g_ph
    logic signed [VG_W-1:0]   vg, next_vg, ig, next_ig;
    logic signed [SMP_W-1:0]  vr, next_vr;
    logic [SQ_W-1:0]          ms, next_ms;
    logic signed [PW_W-1:0]   pacc, next_pacc, p_c;
    ppr_sq_t                  st, next_st;
    logic [RAD_W-1:0]         rad, next_rad;
    logic [REM_W-1:0]         rem, next_rem, trial, shl;
    logic [RMS_W-1:0]         root, next_root, raw, next_raw, vrms, next_vrms;
    logic [4:0]               cnt, next_cnt;
    logic signed [EBUS_W-1:0] apow, next_apow, pw_c;
    logic [STEP_W-1:0]        step, next_step;
    logic signed [SQ_W-1:0]   sq_c;
    logic signed [SQ_W:0]     diff_ms;
    logic signed [PW_W:0]     diff_p;
    logic signed [GM_W-1:0]   wprod;
    logic signed [CORR_W-1:0] corr;

    assign p_c     = ig * vr;
    assign sq_c    = vg * vg;
    assign diff_ms = $signed({1'b0, sq_c}) - $signed({1'b0, ms});
    assign diff_p  = (PW_W+1)'(p_c) - (PW_W+1)'(pacc);
    assign wprod   = gmul(pacc, watt_gain_in[k]);
    assign pw_c    = wprod[GAIN_FRAC + EBUS_SHIFT +: EBUS_W];
    assign step_c[k] = sel[k] ? STEP_W'(pw_c) + STEP_W'($signed(power_offset_in[k])) : '0;
    assign neg_c[k]  = pw_c[EBUS_W-1];
    assign shl     = {rem[RMS_W-1:0], rad[RAD_W-1 -: 2]};
    assign trial   = {root, 2'b01};
    assign corr    = $signed({3'b000, raw})
                   + (CORR_W'($signed(voltage_rms_offset_in[k])) <<< RMSOS_SHIFT);

    always_comb begin
      next_vg   = vg;
      next_ig   = ig;
      next_vr   = vr;
      next_ms   = ms;
      next_pacc = pacc;
      next_st   = st;
      next_rad  = rad;
      next_rem  = rem;
      next_root = root;
      next_cnt  = cnt;
      next_raw  = raw;
      next_vrms = vrms;
      next_apow = apow;
      next_step = step;
      if (pop) begin
        next_vg = VG_W'(gmul(PW_W'($signed(f_volt[k])), voltage_gain_in[k]) >>> GAIN_FRAC);
        next_ig = VG_W'(gmul(PW_W'($signed(f_cur[k])), power_gain_in[k]) >>> GAIN_FRAC);
        next_vr = f_volt[k];
      end
      if (s1_valid) begin
        next_ms   = SQ_W'($signed({1'b0, ms}) + (diff_ms >>> LPF_SHIFT));
        next_pacc = PW_W'((PW_W+1)'(pacc) + (diff_p >>> LPF_SHIFT));
      end
      // bit-serial square root of the mean square
      case (st)
        PPR_SQ_IDLE: begin
          next_rad  = {ms, {RAD_PAD{1'b0}}};
          next_rem  = '0;
          next_root = '0;
          next_cnt  = '0;
          next_st   = PPR_SQ_RUN;
        end
        PPR_SQ_RUN: begin
          next_rad = rad << 2;
          if (shl >= trial) begin
            next_rem  = shl - trial;
            next_root = {root[RMS_W-2:0], 1'b1};
          end else begin
            next_rem  = shl;
            next_root = {root[RMS_W-2:0], 1'b0};
          end
          next_cnt = cnt + 5'h1;
          if (cnt == SQRT_STEPS - 5'h1) begin
            next_st = PPR_SQ_DONE;
          end
        end
        PPR_SQ_DONE: begin
          next_raw = root;
          next_st  = PPR_SQ_IDLE;
        end
        default: begin
          next_st = PPR_SQ_IDLE;
        end
      endcase
      if (rms_pulse) begin
        if (corr[CORR_W-1]) begin
          next_vrms = '0;
        end else if (|corr[CORR_W-2:RMS_W]) begin
          next_vrms = '1;
        end else begin
          next_vrms = corr[RMS_W-1:0];
        end
      end
      if (acc_pulse) begin
        next_apow = pw_c;
        next_step = step_c[k];
      end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        vg   <= '0;
        ig   <= '0;
        vr   <= '0;
        ms   <= '0;
        pacc <= '0;
        st   <= PPR_SQ_IDLE;
        rad  <= '0;
        rem  <= '0;
        root <= '0;
        cnt  <= '0;
        raw  <= '0;
        vrms <= '0;
        apow <= '0;
        step <= '0;
      end else begin
        vg   <= next_vg;
        ig   <= next_ig;
        vr   <= next_vr;
        ms   <= next_ms;
        pacc <= next_pacc;
        st   <= next_st;
        rad  <= next_rad;
        rem  <= next_rem;
        root <= next_root;
        cnt  <= next_cnt;
        raw  <= next_raw;
        vrms <= next_vrms;
        apow <= next_apow;
        step <= next_step;
      end
    end

    assign voltage_gained_out[k] = vg;
    assign voltage_rms_out[k]    = vrms;
    assign active_power_out[k]   = apow;
    assign energy_step_out[k]    = step;
  end

  // ----------------------------------------------------------------
  // dividers, flags and total
  // ----------------------------------------------------------------
  always_comb begin
    next_acc_cnt  = (acc_cnt == ACC_LAST) ? '0 : acc_cnt + 2'h1;
    next_rms_cnt  = (rms_cnt == RMS_LAST) ? '0 : rms_cnt + 4'h1;
    next_s1_valid = pop;
    next_cfn      = cf_numerator_in;
    next_flags    = flags;
    next_total    = total;
    if (acc_pulse) begin
      next_flags = sel & neg_c;
      next_total = '0;
      for (int k = 0; k < NPH; k++) begin
        next_total = next_total + TOT_W'($signed(step_c[k]));
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_cnt  <= '0;
      rms_cnt  <= '0;
      s1_valid <= 1'b0;
      cfn      <= '0;
      flags    <= '0;
      total    <= '0;
    end else begin
      acc_cnt  <= next_acc_cnt;
      rms_cnt  <= next_rms_cnt;
      s1_valid <= next_s1_valid;
      cfn      <= next_cfn;
      flags    <= next_flags;
      total    <= next_total;
    end
  end

  // bit 15 is unused and reads zero
  assign total_power_out  = total;
  assign freq_div_reg_out = {1'b0, flags, cfn};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_acc_gap;
    !acc_pulse [*3] ##1 acc_pulse;
  endsequence
  sequence s_rms_quiet;
    !rms_pulse [*8];
  endsequence

  property p_acc_rate;
    acc_pulse |=> s_acc_gap;
  endproperty
  a_acc_rate: assert property (p_acc_rate) else $error("step spacing wrong");

  property p_rms_rate;
    rms_pulse |=> s_rms_quiet ##1 !rms_pulse [*3] ##1 rms_pulse;
  endproperty
  a_rms_rate: assert property (p_rms_rate) else $error("rms period not 12");

  property p_rms_hold;
    !rms_pulse |=> $stable(g_ph[1].vrms);
  endproperty
  a_rms_hold: assert property (p_rms_hold) else $error("rms moved off tick");

  property p_rms_off;
    rms_pulse && !g_ph[0].corr[CORR_W-1] && !(|g_ph[0].corr[CORR_W-2:RMS_W]) |=>
      $signed({3'b000, g_ph[0].vrms}) - $signed({3'b000, $past(g_ph[0].raw)})
        == (CORR_W'($signed($past(voltage_rms_offset_in[0]))) <<< RMSOS_SHIFT);
  endproperty
  a_rms_off: assert property (p_rms_off) else $error("rms offset not x64");

  property p_gain_unity;
    pop && voltage_gain_in[0] == '0 |=> g_ph[0].vg == VG_W'($signed($past(f_volt[0])));
  endproperty
  a_gain_unity: assert property (p_gain_unity) else $error("zero gain altered sample");

  property p_gain_half;
    pop && voltage_gain_in[1] == GAIN_MIN |=>
      g_ph[1].vg == VG_W'($signed($past(f_volt[1])) >>> 1);
  endproperty
  a_gain_half: assert property (p_gain_half) else $error("min gain not half");

  property p_sqrt_len;
    g_ph[0].st == PPR_SQ_IDLE |-> ##25 g_ph[0].st == PPR_SQ_DONE;
  endproperty
  a_sqrt_len: assert property (p_sqrt_len) else $error("root latency wrong");

  property p_step;
    acc_pulse && sel[1] |=> energy_step_out[1]
      == STEP_W'($past(g_ph[1].pw_c)) + STEP_W'($signed($past(power_offset_in[1])));
  endproperty
  a_step: assert property (p_step) else $error("power offset not added");

  property p_flag_gate;
    acc_pulse && !sel[1] |=> !freq_div_reg_out[FD_FLAG_LSB+1] throughout s_acc_gap;
  endproperty
  a_flag_gate: assert property (p_flag_gate) else $error("flag set while deselected");

  property p_flag_sign;
    acc_pulse && sel[1] |=> freq_div_reg_out[FD_FLAG_LSB+1] == $past(g_ph[1].pw_c[EBUS_W-1]);
  endproperty
  a_flag_sign: assert property (p_flag_sign) else $error("flag not power sign");

  property p_total_none;
    acc_pulse && sel == '0 |=> total_power_out == '0;
  endproperty
  a_total_none: assert property (p_total_none) else $error("deselected term summed");

  property p_lpf_dc;
    s1_valid && g_ph[0].p_c == g_ph[0].pacc |=> $stable(g_ph[0].pacc);
  endproperty
  a_lpf_dc: assert property (p_lpf_dc) else $error("filter moved at dc");
endmodule

// File: testbench/ppr_src_model.sv
// adc sample source model feeding the sample stream of the calibration datapath
`timescale 1ns/1ns
module ppr_src_model
  import ppr_pkg::*;
(
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      run_in,
  input  wire logic                      slow_in,
  input  wire logic [NPH-1:0][SMP_W-1:0] cur_val_in,
  input  wire logic [NPH-1:0][SMP_W-1:0] volt_val_in,
  input  wire logic                      smp_ready_in,
  output logic                           smp_valid_out,
  output logic      [NPH-1:0][SMP_W-1:0] cur_smp_out,
  output logic      [NPH-1:0][SMP_W-1:0] volt_smp_out
);
  logic hit;

  initial begin
    hit = 1'b0;
    smp_valid_out = 1'b0;
    cur_smp_out = '0;
    volt_smp_out = '0;
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    hit <= rst_in ? 1'b0 : (smp_valid_out & smp_ready_in);
  end

  // ----------------------------------------------------------------
  // offer one sample set, held until taken
  // ----------------------------------------------------------------
  // paired current and voltage
  always @(negedge core_clk_in) begin
    if (rst_in) begin
      smp_valid_out <= 1'b0;
    end else if (!smp_valid_out || hit) begin
      if (run_in && !(slow_in && hit)) begin
        smp_valid_out <= 1'b1;
        cur_smp_out   <= cur_val_in;
        volt_smp_out  <= volt_val_in;
      end else begin
        // released lines do not keep the last value
        smp_valid_out <= 1'b0;
        cur_smp_out   <= ~cur_smp_out;
        volt_smp_out  <= ~volt_smp_out;
      end
    end
  end
endmodule

// File: testbench/phase_power_rms_calibration_test.sv
// self-checking bench for the per-phase calibration datapath
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
`define WAIT_EQ(a, b, n) begin for (int k = 0; k < (n) && (a) !== (b); k++) \
  @(negedge core_clk_in); `CHK(a, b) if ((a) !== (b)) wrap_up(); end
module phase_power_rms_calibration_test import ppr_pkg::*;;
  logic                       core_clk_in;
  logic                       rst_in;
  logic                       run;
  logic                       slow;
  logic                       smp_valid;
  logic                       smp_ready;
  logic [NPH-1:0][SMP_W-1:0]  cur_val;
  logic [NPH-1:0][SMP_W-1:0]  volt_val;
  logic [NPH-1:0][SMP_W-1:0]  cur_smp;
  logic [NPH-1:0][SMP_W-1:0]  volt_smp;
  logic [NPH-1:0][GAIN_W-1:0] voltage_gain;
  logic [NPH-1:0][GAIN_W-1:0] rmsos;
  logic [NPH-1:0][GAIN_W-1:0] pgain;
  logic [NPH-1:0][GAIN_W-1:0] wgain;
  logic [NPH-1:0][GAIN_W-1:0] poff;
  logic [7:0]                 wmode;
  logic [CFN_W-1:0]           cfn;
  logic [NPH-1:0][VG_W-1:0]   vg;
  logic [NPH-1:0][RMS_W-1:0]  vr;
  logic [NPH-1:0][EBUS_W-1:0] ap;
  logic [NPH-1:0][STEP_W-1:0] es;
  logic [TOT_W-1:0]           tp;
  logic [15:0]                fd;
  int                         error_cnt = 0;
  int                         checks = 0;

  always #5 core_clk_in = ~core_clk_in;

  ppr_src_model u_src (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .run_in(run), .slow_in(slow),
    .cur_val_in(cur_val), .volt_val_in(volt_val), .smp_ready_in(smp_ready),
    .smp_valid_out(smp_valid), .cur_smp_out(cur_smp), .volt_smp_out(volt_smp)
  );

  ppr_phase_calib u_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .smp_valid_in(smp_valid),
    .smp_ready_out(smp_ready), .cur_smp_in(cur_smp), .volt_smp_in(volt_smp),
    .voltage_gain_in(voltage_gain), .voltage_rms_offset_in(rmsos), .power_gain_in(pgain),
    .watt_gain_in(wgain), .power_offset_in(poff), .watt_mode_in(wmode),
    .cf_numerator_in(cfn), .voltage_gained_out(vg), .voltage_rms_out(vr),
    .active_power_out(ap), .energy_step_out(es), .total_power_out(tp),
    .freq_div_reg_out(fd)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (12) @(negedge core_clk_in);
    `CHK(vr, '0)
    `CHK(fd, 16'h0000)
    `CHK(smp_ready, 1'b1)
    rst_in = 1'b0;
    @(negedge core_clk_in);
    `CHK(es, '0)
    $display("test reset done");
  endtask

  // zero input, so the corrected result is the scaled offset alone
  task automatic t_rms();
    // gain stays zero, volts per code is host side
    // offset given as the host fitted it
    rmsos = {12'h800, 12'h7ff, 12'h010};
    run = 1'b1;
    `WAIT_EQ(vr[0], 24'h000400, 300)
    `CHK(vr[1], 24'h01ffc0)
    `CHK(vr[2], 24'h000000)
    $display("test rms offset done");
  endtask

  task automatic t_gain();
    @(negedge core_clk_in);
    volt_val = {16'hf000, 16'h1000, 16'h1000};
    voltage_gain = {12'h7ff, 12'h800, 12'h000};
    `WAIT_EQ(vg[0], 17'h01000, 60)
    `WAIT_EQ(vg[1], 17'h00800, 60)
    `WAIT_EQ(vg[2], 17'h1e801, 60)
    $display("test voltage gain done");
  endtask

  // a positive, b negative, c idle; offsets of both signs
  task automatic t_power();
    @(negedge core_clk_in);
    voltage_gain = '0;
    poff = {12'h800, 12'hffb, 12'h005};
    wmode = 8'h38;
    cfn = 12'h123;
    cur_val = {16'h0000, 16'hc001, 16'h3fff};
    volt_val = {16'h0201, 16'h0201, 16'h0201};
    `WAIT_EQ(ap[0], 28'h00200f7, 3000)
    `WAIT_EQ(ap[1], 28'hffdff08, 3000)
    `CHK(ap[2], 28'h0000000)
    `WAIT_EQ(es[0], 29'h00200fc, 20)
    `WAIT_EQ(es[1], 29'h1ffdff03, 20)
    `WAIT_EQ(es[2], 29'h1ffff800, 20)
    `WAIT_EQ(tp, 31'h7ffff7ff, 20)
    `WAIT_EQ(fd, 16'h2123, 20)
    wmode = 8'h28;
    `WAIT_EQ(es[1], 29'h0, 20)
    `WAIT_EQ(fd, 16'h0123, 20)
    `WAIT_EQ(tp, 31'h001f8fc, 20)
    wgain = {12'h000, 12'h000, 12'h800};
    `WAIT_EQ(ap[0], 28'h001007b, 20)
    $display("test active power done");
  endtask

  // source stops so the buffer drains, then refills faster than it drains
  task automatic t_fifo();
    run = 1'b0;
    `WAIT_EQ(smp_ready, 1'b1, 40)
    slow = 1'b1;
    run = 1'b1;
    `WAIT_EQ(smp_ready, 1'b0, 60)
    $display("test buffer done");
  endtask

  initial begin
    core_clk_in = 1'b0;
    rst_in = 1'b1;
    run = 1'b0;
    slow = 1'b0;
    cur_val = '0;
    volt_val = '0;
    voltage_gain = '0;
    rmsos = '0;
    pgain = '0;
    wgain = '0;
    poff = '0;
    wmode = 8'h00;
    cfn = '0;
    t_reset();
    t_rms();
    t_gain();
    t_power();
    t_fifo();
    wrap_up();
  end
endmodule
